// ---- rtl/cpu_bus_cycle_sequencer.sv ----
// bus cycle sequencer: per-instruction cycle types, addresses and sizes
// assumes instruction requests, coprocessor and memory on the same clock
//
// What this block does
// - next type 00 means internal cycle, 01 coprocessor transfer
// - next type 10 nonsequential access, 11 sequential access
// - next type is driven in the cycle before the one it describes
// - address, size, write, opcode flag, state are registered; lock is tied low
// - sequential fetches advance 4 bytes wide, 2 bytes narrow
// - word, halfword or byte transfer chosen by data or opcode width
// - fetch size code 2 in wide state, 1 in narrow state
// - coprocessor absent and busy are acted on one cycle after driving
// - a low clock enable stretches every cycle by the frozen clocks
// - failed condition takes one sequential cycle, nothing more
// - multiply internal cycles end early by operand sign extension
// - coprocessor ops busy-wait, then their own transfer pattern
// - multi load N, S..., I, S; multi store N, S..., I, N
// - branch: compute while prefetching, fetch target, target plus one
// - wide branch with link writes link, then subtracts 4
// - narrow long link: one setup cycle then three-cycle branch
// - narrow link branch fetches target plus 2, subtracts 2 from link
// - exchange branch takes target and state from operand register
// - state output low wide, high narrow, switches in second cycle
`timescale 1ns/100ps
module cpu_bus_cycle_sequencer #(
  parameter int unsigned COUNT_W = 5
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cycle_advance_enable,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire cycle_seq_pkg::kind_t instr_kind,
  input wire logic instr_cond_pass,
  input wire logic [31:0] instr_operand,
  input wire logic [COUNT_W-1:0] instr_count,
  input wire logic [1:0] instr_size,
  input wire logic coproc_absent,
  input wire logic coproc_busy,
  output logic [31:0] bus_addr,
  output logic bus_lock,
  output logic [1:0] bus_size,
  output logic bus_write,
  output logic opcode_or_data_flag,
  output logic instruction_state_out,
  output logic [1:0] next_cycle_type,
  output logic [31:0] link_register,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [3:0] {
    st_idle, st_first, st_br2, st_br3, st_mul,
    st_cp_wait, st_cp_xfer, st_cp_tail, st_beat, st_mem_int
  } state_t;

  state_t state_reg, state_next;
  cycle_seq_pkg::kind_t kind_reg;
  logic cond_reg, store_reg, en, start, last, is_link, absent_set;
  logic [1:0] dsize_reg;
  logic [COUNT_W-1:0] count_reg, count_next;
  logic [31:0] mem_reg, mem_next, fetch_reg, fetch_next;
  logic [31:0] link_reg, link_next, addr_reg, addr_next;
  logic tstate_reg, tstate_next, write_reg, write_next;
  logic flag_reg, flag_next;
  logic [1:0] size_reg, size_next, trans_reg, trans_next;
  logic run_reg, absent_reg;
  logic [31:0] prdata_reg;
  logic apb_wr, mapped;

  function automatic logic [31:0] inc_of(input logic t);
    return t ? cycle_seq_pkg::INC_NARROW : cycle_seq_pkg::INC_WIDE;
  endfunction

  function automatic logic [1:0] fsize_of(input logic t);
    return t ? cycle_seq_pkg::SIZE_HALF : cycle_seq_pkg::SIZE_WORD;
  endfunction

  function automatic logic [31:0] bytes_of(input logic [1:0] s);
    unique case (s)
      cycle_seq_pkg::SIZE_BYTE: return cycle_seq_pkg::INC_BYTE;
      cycle_seq_pkg::SIZE_HALF: return cycle_seq_pkg::INC_HALF;
      default: return cycle_seq_pkg::INC_WIDE;
    endcase
  endfunction

  // m-1 from the multiplier operand
  function automatic logic [1:0] mul_extra(input logic [31:0] op);
    if (&op[31:8] || ~|op[31:8]) return 2'h0;
    else if (&op[31:16] || ~|op[31:16]) return 2'h1;
    else if (&op[31:24] || ~|op[31:24]) return 2'h2;
    else return 2'h3;
  endfunction

  // coprocessor handshake, sampled at the edge closing the driving cycle
  function automatic logic [1:0] cp_trans(input cycle_seq_pkg::kind_t k,
      input logic busy, input logic absent);
    if (absent) return cycle_seq_pkg::TRANS_S;
    else if (busy) return cycle_seq_pkg::TRANS_I;
    else if (k == cycle_seq_pkg::kind_coproc_data_op)
      return cycle_seq_pkg::TRANS_S;
    else return cycle_seq_pkg::TRANS_C;
  endfunction

  assign en = cycle_advance_enable;
  assign start = instr_valid && instr_ready && en;
  assign instr_ready = last && run_reg;
  assign is_link = kind_reg == cycle_seq_pkg::kind_branch_link ||
                   kind_reg == cycle_seq_pkg::kind_long_link_lo;

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    size_next = size_reg;
    write_next = 1'b0;
    flag_next = cycle_seq_pkg::FLAG_DATA;
    trans_next = trans_reg;
    fetch_next = fetch_reg;
    mem_next = mem_reg;
    count_next = count_reg;
    link_next = link_reg;
    tstate_next = tstate_reg;
    absent_set = 1'b0;
    last = 1'b0;
    unique case (state_reg)
      st_idle, st_br3, st_mem_int, st_cp_tail: last = 1'b1;
      st_first: begin
        if (!cond_reg) begin
          last = 1'b1;
        end else begin
          unique case (kind_reg)
            cycle_seq_pkg::kind_data, cycle_seq_pkg::kind_long_link_hi: begin
              last = 1'b1;
            end
            cycle_seq_pkg::kind_branch, cycle_seq_pkg::kind_branch_link,
            cycle_seq_pkg::kind_long_link_lo,
            cycle_seq_pkg::kind_branch_exchange: begin
              state_next = st_br2;
              if (kind_reg == cycle_seq_pkg::kind_branch_exchange) begin
                tstate_next = mem_reg[0];
                addr_next = {mem_reg[31:1], 1'b0};
              end else begin
                addr_next = mem_reg;
              end
              size_next = fsize_of(tstate_next);
              flag_next = cycle_seq_pkg::FLAG_OPCODE;
              trans_next = cycle_seq_pkg::TRANS_S;
              if (is_link) begin
                link_next = addr_reg;
              end
            end
            cycle_seq_pkg::kind_mul: begin
              state_next = st_mul;
              addr_next = fetch_reg;
              trans_next = count_reg == '0 ? cycle_seq_pkg::TRANS_S
                                           : cycle_seq_pkg::TRANS_I;
              count_next = count_reg - 1'b1;
            end
            cycle_seq_pkg::kind_multi_load,
            cycle_seq_pkg::kind_multi_store: begin
              state_next = st_beat;
              addr_next = mem_reg;
              size_next = dsize_reg;
              write_next = store_reg;
              trans_next = count_reg == '0 ? cycle_seq_pkg::TRANS_I
                                           : cycle_seq_pkg::TRANS_S;
              mem_next = mem_reg + bytes_of(dsize_reg);
              count_next = count_reg - 1'b1;
            end
            default: begin
              if (trans_reg == cycle_seq_pkg::TRANS_I) begin
                state_next = st_cp_wait;
                addr_next = fetch_reg;
                trans_next = cp_trans(kind_reg, coproc_busy, coproc_absent);
                absent_set = coproc_absent;
              end else if (trans_reg == cycle_seq_pkg::TRANS_C) begin
                state_next = st_cp_xfer;
                addr_next = fetch_reg;
                write_next = kind_reg == cycle_seq_pkg::kind_move_to_coproc;
                trans_next = write_next ? cycle_seq_pkg::TRANS_N
                                        : cycle_seq_pkg::TRANS_I;
              end else begin
                last = 1'b1;
              end
            end
          endcase
        end
      end
      st_br2: begin
        state_next = st_br3;
        addr_next = addr_reg + inc_of(tstate_reg);
        flag_next = cycle_seq_pkg::FLAG_OPCODE;
        trans_next = cycle_seq_pkg::TRANS_S;
        fetch_next = addr_reg + inc_of(tstate_reg) + inc_of(tstate_reg);
        if (is_link) begin
          link_next = link_reg - inc_of(tstate_reg);
        end
      end
      st_mul: begin
        if (trans_reg == cycle_seq_pkg::TRANS_S) begin
          last = 1'b1;
        end else begin
          trans_next = count_reg == '0 ? cycle_seq_pkg::TRANS_S
                                       : cycle_seq_pkg::TRANS_I;
          count_next = count_reg - 1'b1;
        end
      end
      st_cp_wait: begin
        if (trans_reg == cycle_seq_pkg::TRANS_I) begin
          trans_next = cp_trans(kind_reg, coproc_busy, coproc_absent);
          absent_set = coproc_absent;
        end else if (trans_reg == cycle_seq_pkg::TRANS_C) begin
          state_next = st_cp_xfer;
          write_next = kind_reg == cycle_seq_pkg::kind_move_to_coproc;
          trans_next = write_next ? cycle_seq_pkg::TRANS_N
                                  : cycle_seq_pkg::TRANS_I;
        end else begin
          last = 1'b1;
        end
      end
      st_cp_xfer: begin
        if (trans_reg == cycle_seq_pkg::TRANS_N) begin
          last = 1'b1;
        end else begin
          state_next = st_cp_tail;
          trans_next = cycle_seq_pkg::TRANS_S;
        end
      end
      st_beat: begin
        if (trans_reg == cycle_seq_pkg::TRANS_I) begin
          state_next = st_mem_int;
          trans_next = store_reg ? cycle_seq_pkg::TRANS_N
                                 : cycle_seq_pkg::TRANS_S;
        end else begin
          addr_next = mem_reg;
          write_next = store_reg;
          trans_next = count_reg == '0 ? cycle_seq_pkg::TRANS_I
                                       : cycle_seq_pkg::TRANS_S;
          mem_next = mem_reg + bytes_of(dsize_reg);
          count_next = count_reg - 1'b1;
        end
      end
    endcase
    if (last) begin
      // a new instruction starts with a prefetch at the fetch pointer
      addr_next = fetch_reg;
      size_next = fsize_of(tstate_reg);
      write_next = 1'b0;
      flag_next = cycle_seq_pkg::FLAG_OPCODE;
      if (start) begin
        state_next = st_first;
        fetch_next = fetch_reg + inc_of(tstate_reg);
        mem_next = instr_operand;
        count_next = instr_count == '0 ? '0 : instr_count - 1'b1;
        if (!instr_cond_pass) begin
          trans_next = cycle_seq_pkg::TRANS_S;
        end else begin
          unique case (instr_kind)
            cycle_seq_pkg::kind_data: trans_next = cycle_seq_pkg::TRANS_S;
            cycle_seq_pkg::kind_long_link_hi: begin
              trans_next = cycle_seq_pkg::TRANS_S;
              link_next = fetch_reg + instr_operand;
            end
            cycle_seq_pkg::kind_mul: begin
              trans_next = cycle_seq_pkg::TRANS_I;
              count_next = COUNT_W'(mul_extra(instr_operand));
            end
            cycle_seq_pkg::kind_coproc_data_op,
            cycle_seq_pkg::kind_move_to_coproc,
            cycle_seq_pkg::kind_move_from_coproc: begin
              trans_next = cp_trans(instr_kind, coproc_busy, coproc_absent);
              absent_set = coproc_absent;
            end
            default: trans_next = cycle_seq_pkg::TRANS_N;
          endcase
        end
      end else begin
        state_next = st_idle;
        trans_next = cycle_seq_pkg::TRANS_I;
      end
    end
  end

  // sequence state, frozen while the clock enable is low
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= st_idle;
      kind_reg <= cycle_seq_pkg::kind_data;
      cond_reg <= 1'b0;
      store_reg <= 1'b0;
      dsize_reg <= cycle_seq_pkg::SIZE_WORD;
      count_reg <= '0;
      mem_reg <= '0;
    end else if (en) begin
      state_reg <= state_next;
      count_reg <= count_next;
      mem_reg <= mem_next;
      if (start) begin
        kind_reg <= instr_kind;
        cond_reg <= instr_cond_pass;
        store_reg <= instr_kind == cycle_seq_pkg::kind_multi_store;
        dsize_reg <= instr_size;
      end
    end
  end

  // bus row of the cycle being entered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= cycle_seq_pkg::FETCH_RESET;
      size_reg <= cycle_seq_pkg::SIZE_WORD;
      write_reg <= 1'b0;
      flag_reg <= cycle_seq_pkg::FLAG_OPCODE;
      trans_reg <= cycle_seq_pkg::TRANS_I;
    end else if (en) begin
      addr_reg <= addr_next;
      size_reg <= size_next;
      write_reg <= write_next;
      flag_reg <= flag_next;
      trans_reg <= trans_next;
    end
  end

  // fetch pointer, link and instruction state; a software write to the fetch pointer wins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fetch_reg <= cycle_seq_pkg::FETCH_RESET;
      link_reg <= cycle_seq_pkg::LINK_RESET;
      tstate_reg <= 1'b0;
    end else if (en) begin
      link_reg <= link_next;
      tstate_reg <= tstate_next;
      if (apb_wr && paddr == cycle_seq_pkg::FETCH_OFFSET) begin
        fetch_reg <= pwdata;
      end else begin
        fetch_reg <= fetch_next;
      end
    end
  end

  assign bus_addr = addr_reg;
  assign bus_lock = 1'b0; // no locked sequences issued here
  assign bus_size = size_reg;
  assign bus_write = write_reg;
  assign opcode_or_data_flag = flag_reg;
  assign instruction_state_out = tstate_reg;
  assign next_cycle_type = trans_reg;
  assign link_register = link_reg;

  // register slave; a frozen clock stretches the access phase
  assign mapped = paddr == cycle_seq_pkg::CTRL_OFFSET ||
                  paddr == cycle_seq_pkg::FETCH_OFFSET ||
                  paddr == cycle_seq_pkg::STATUS_OFFSET ||
                  paddr == cycle_seq_pkg::LINK_OFFSET;
  assign pready = en;
  assign pslverr = psel && penable && !mapped;
  assign apb_wr = psel && penable && pwrite && mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_reg <= cycle_seq_pkg::CTRL_RUN_RESET;
      absent_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (en) begin
      if (apb_wr && paddr == cycle_seq_pkg::CTRL_OFFSET) begin
        run_reg <= pwdata[cycle_seq_pkg::CTRL_RUN_BIT];
      end
      // set wins over the write-one clear
      if (absent_set) begin
        absent_reg <= 1'b1;
      end else if (apb_wr && paddr == cycle_seq_pkg::STATUS_OFFSET &&
                   pwdata[cycle_seq_pkg::STATUS_ABSENT_BIT]) begin
        absent_reg <= 1'b0;
      end
      if (psel && !penable) begin
        prdata_reg <= '0;
        unique case (paddr)
          cycle_seq_pkg::CTRL_OFFSET:
            prdata_reg[cycle_seq_pkg::CTRL_RUN_BIT] <= run_reg;
          cycle_seq_pkg::FETCH_OFFSET: prdata_reg <= fetch_reg;
          cycle_seq_pkg::STATUS_OFFSET: begin
            prdata_reg[cycle_seq_pkg::STATUS_BUSY_BIT] <= state_reg != st_idle;
            prdata_reg[cycle_seq_pkg::STATUS_STATE_BIT] <= tstate_reg;
            prdata_reg[cycle_seq_pkg::STATUS_ABSENT_BIT] <= absent_reg;
          end
          cycle_seq_pkg::LINK_OFFSET: prdata_reg <= link_reg;
          default: prdata_reg <= '0;
        endcase
      end
    end
  end

  AST_BRANCH_N: assert property (@(posedge clock) disable iff (!nrst)
    start && instr_cond_pass && instr_kind == cycle_seq_pkg::kind_branch
    |=> next_cycle_type == cycle_seq_pkg::TRANS_N)
    else $error("branch first cycle not announcing nonsequential");
  AST_BRANCH_LEN: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == st_br2 && en |=> state_reg == st_br3 && last)
    else $error("branch did not end in its third cycle");
  AST_TARGET_INC: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == st_br2 && en
    |=> bus_addr == $past(bus_addr) + (instruction_state_out ? 32'h2 : 32'h4))
    else $error("third branch fetch not at target plus length");
  AST_FETCH_SIZE: assert property (@(posedge clock) disable iff (!nrst)
    opcode_or_data_flag == cycle_seq_pkg::FLAG_OPCODE
    |-> bus_size == (instruction_state_out ? 2'h1 : 2'h2))
    else $error("opcode fetch size does not match state");
  AST_FETCH_READ: assert property (@(posedge clock) disable iff (!nrst)
    opcode_or_data_flag == cycle_seq_pkg::FLAG_OPCODE |-> !bus_write)
    else $error("opcode fetch marked as write");
  AST_LINK_DEC: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == st_br2 && en && is_link
    |=> link_register == $past(link_register)
                         - (instruction_state_out ? 32'h2 : 32'h4))
    else $error("link register not reduced by instruction length");
  AST_MUL_SHORT: assert property (@(posedge clock) disable iff (!nrst)
    start && instr_cond_pass && instr_kind == cycle_seq_pkg::kind_mul &&
    instr_operand[31:8] == 24'h0
    |=> next_cycle_type == cycle_seq_pkg::TRANS_I
    ##1 (!$past(en) || next_cycle_type == cycle_seq_pkg::TRANS_S))
    else $error("short multiply did not end after one internal cycle");
  AST_UNEXEC: assert property (@(posedge clock) disable iff (!nrst)
    start && !instr_cond_pass
    |=> next_cycle_type == cycle_seq_pkg::TRANS_S && last)
    else $error("failed condition took more than one cycle");
  AST_EXCH_STATE: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == st_first && en && cond_reg &&
    kind_reg == cycle_seq_pkg::kind_branch_exchange
    |=> instruction_state_out == $past(mem_reg[0]))
    else $error("state output not switched in second exchange cycle");
  AST_MULTI_END: assert property (@(posedge clock) disable iff (!nrst)
    state_reg == st_mem_int
    |-> next_cycle_type == (store_reg ? 2'h2 : 2'h3))
    else $error("multiple transfer ended with wrong cycle type");
  AST_FREEZE: assert property (@(posedge clock) disable iff (!nrst)
    !en |=> $stable(bus_addr) && $stable(next_cycle_type) &&
            $stable(state_reg))
    else $error("state moved while clock enable was low");
endmodule

// ---- common/cycle_seq_pkg.sv ----
// constants and types shared by the bus cycle sequencer
// assumes a single clock domain; the register offsets are byte addresses
package cycle_seq_pkg;
  // next-cycle type codes
  localparam logic [1:0] TRANS_I = 2'h0;
  localparam logic [1:0] TRANS_C = 2'h1;
  localparam logic [1:0] TRANS_N = 2'h2;
  localparam logic [1:0] TRANS_S = 2'h3;
  // transfer size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // instruction and transfer lengths in bytes
  localparam logic [31:0] INC_WIDE = 32'h4;
  localparam logic [31:0] INC_NARROW = 32'h2;
  localparam logic [31:0] INC_HALF = 32'h2;
  localparam logic [31:0] INC_BYTE = 32'h1;
  // opcode_or_data_flag values
  localparam logic FLAG_OPCODE = 1'h0;
  localparam logic FLAG_DATA = 1'h1;
  // register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] FETCH_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] LINK_OFFSET = 8'h0c;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_STATE_BIT = 1;
  localparam int STATUS_ABSENT_BIT = 2;
  localparam logic CTRL_RUN_RESET = 1'h1;
  localparam logic [31:0] FETCH_RESET = 32'h0;
  localparam logic [31:0] LINK_RESET = 32'h0;
  typedef enum logic [3:0] {
    kind_data,
    kind_branch,
    kind_branch_link,
    kind_long_link_hi,
    kind_long_link_lo,
    kind_branch_exchange,
    kind_mul,
    kind_multi_load,
    kind_multi_store,
    kind_coproc_data_op,
    kind_move_to_coproc,
    kind_move_from_coproc
  } kind_t;
endpackage

// ---- dv/bus_partner.sv ----
// far side model: memory wait states and an idle coprocessor
// assumes the sequencer clock; stalls are random only while asked for
`timescale 1ns/100ps
module bus_partner (
  input wire logic clock,
  input wire logic nrst,
  input wire logic stall_on,
  output logic cycle_advance_enable,
  output logic coproc_absent,
  output logic coproc_busy
);
  // wait states only through a low enable, so rows must merely stretch
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) cycle_advance_enable <= 1'b1;
    else cycle_advance_enable <= !stall_on || ($urandom_range(1, 0) == 1);
  end
  // present and never busy, driven a cycle ahead of use
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) {coproc_absent, coproc_busy} <= 2'h0;
    else {coproc_absent, coproc_busy} <= 2'h0;
  end
endmodule

// ---- dv/tb.sv ----
// self-checking bench: branches, multiplies, apb registers, stalls
// assumes the sequencer and bus_partner; expectations kept in fp and nar
`timescale 1ns/100ps
module tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic stall_on = 1'b0;
  logic instr_valid = 1'b0;
  logic instr_cond_pass = 1'b1;
  cycle_seq_pkg::kind_t instr_kind = cycle_seq_pkg::kind_data;
  logic [31:0] instr_operand = 32'h0;
  logic [4:0] instr_count = 5'h1;
  logic [1:0] instr_size = 2'h2;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] bus_addr, link_register, prdata, fp, q, lk;
  logic [1:0] bus_size, next_cycle_type;
  logic bus_lock, bus_write, opcode_or_data_flag, instruction_state_out;
  logic pready, pslverr, instr_ready, coproc_absent, coproc_busy;
  logic cycle_advance_enable, nar, e;
  int mismatches = 0, compares = 0, cycles = 0;
  logic [31:0] mops [5] = '{32'h7f, 32'hffffff80, 32'h1234, 32'h123456,
                            32'h12345678};
  always #12.5 clock = ~clock;
  bus_partner far (.clock, .nrst, .stall_on, .cycle_advance_enable,
    .coproc_absent, .coproc_busy);
  cpu_bus_cycle_sequencer #(.COUNT_W(5)) uut (.clock, .nrst,
    .cycle_advance_enable, .instr_valid, .instr_ready, .instr_kind,
    .instr_cond_pass, .instr_operand, .instr_count, .instr_size,
    .coproc_absent, .coproc_busy, .bus_addr, .bus_lock, .bus_size,
    .bus_write, .opcode_or_data_flag, .instruction_state_out,
    .next_cycle_type, .link_register, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(string w, logic [31:0] x, logic [31:0] g);
    compares++;
    if (x !== g) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, x, g);
    end
  endtask
  function automatic int mcount(logic [31:0] v);
    if (&v[31:8] || ~|v[31:8]) return 1;
    if (&v[31:16] || ~|v[31:16]) return 2;
    if (&v[31:24] || ~|v[31:24]) return 3;
    return 4;
  endfunction
  task automatic en();
    do @(negedge clock); while (cycle_advance_enable !== 1'b1);
  endtask
  task automatic row(logic [31:0] a, logic [1:0] t, logic st, logic ck);
    en();
    chk("type", t, next_cycle_type);
    if (ck) begin
      chk("addr", a, bus_addr);
      chk("size", st ? cycle_seq_pkg::SIZE_HALF : 2'h2, bus_size);
      chk("state", st, instruction_state_out);
      chk("wr_flag", 2'h0, {bus_write, opcode_or_data_flag});
      chk("lock", 32'h0, bus_lock);
    end
  endtask
  task automatic issue(cycle_seq_pkg::kind_t k, logic c, logic [31:0] op);
    @(posedge clock);
    instr_kind <= k;
    instr_cond_pass <= c;
    instr_operand <= op;
    instr_valid <= 1'b1;
    do @(negedge clock); while (!(instr_ready === 1'b1 &&
      cycle_advance_enable === 1'b1));
    @(posedge clock);
    instr_valid <= 1'b0;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // link kinds check the return address once the refill has settled
  task automatic branch(cycle_seq_pkg::kind_t k, logic [31:0] tg);
    logic [31:0] f, t, i;
    logic nn;
    f = fp;
    t = {tg[31:1], 1'b0};
    nn = (k == cycle_seq_pkg::kind_branch_exchange) ? tg[0] : nar;
    i = nn ? 32'h2 : 32'h4;
    issue(k, 1'b1, tg);
    row(f, cycle_seq_pkg::TRANS_N, nar, 1'b1);
    row(t, cycle_seq_pkg::TRANS_S, nn, 1'b1);
    row(t + i, cycle_seq_pkg::TRANS_S, nn, 1'b1);
    fp = t + 2 * i;
    nar = nn;
    if (k == cycle_seq_pkg::kind_branch_link ||
        k == cycle_seq_pkg::kind_long_link_lo) begin
      en();
      en();
      lk = f - i;
      chk("link", lk, link_register);
    end
    $display("test branch kind %0d done", k);
  endtask
  // multi transfers: N, beats of a random size, the last beat announces I
  task automatic multi(cycle_seq_pkg::kind_t k, logic [4:0] n);
    logic [31:0] b, s;
    logic [1:0] t;
    logic w;
    b = $urandom & 32'hfffffffc;
    s = $urandom_range(2, 0);
    w = k == cycle_seq_pkg::kind_multi_store;
    @(posedge clock);
    instr_count <= n;
    instr_size <= s[1:0];
    issue(k, 1'b1, b);
    row(fp, cycle_seq_pkg::TRANS_N, nar, 1'b1);
    for (int j = 0; j < n; j++) begin
      t = (j == n - 1) ? cycle_seq_pkg::TRANS_I : cycle_seq_pkg::TRANS_S;
      row(fp, t, nar, 1'b0);
      chk("beat_addr", b + (j << s), bus_addr);
      chk("beat_size", s, bus_size);
      chk("beat_write", w, bus_write);
    end
    t = w ? cycle_seq_pkg::TRANS_N : cycle_seq_pkg::TRANS_S;
    row(fp, t, nar, 1'b0);
    fp = fp + 4;
    $display("test multi kind %0d done", k);
  endtask
  initial begin
    q = $urandom(32'ha5ca);
    nar = 1'b0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    chk("rst_type", cycle_seq_pkg::TRANS_I, next_cycle_type);
    apb(1'b0, cycle_seq_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl", 32'h1, q);
    apb(1'b1, cycle_seq_pkg::FETCH_OFFSET, 32'h100);
    apb(1'b0, cycle_seq_pkg::FETCH_OFFSET, 32'h0);
    chk("fetch", 32'h100, q);
    chk("slverr_ok", 32'h0, e);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, e);
    chk("unmapped", 32'h0, q);
    $display("test apb done");
    fp = 32'h100;
    branch(cycle_seq_pkg::kind_branch, 32'h2000);
    issue(cycle_seq_pkg::kind_branch, 1'b0, 32'h0);
    row(fp, cycle_seq_pkg::TRANS_S, 1'b0, 1'b1);
    fp = fp + 4;
    branch(cycle_seq_pkg::kind_branch_link, $urandom & 32'hfffffffc);
    for (int j = 0; j < 6; j++) begin
      q = (j < 5) ? mops[j] : $urandom;
      issue(cycle_seq_pkg::kind_mul, 1'b1, q);
      repeat (mcount(q)) begin
        row(fp, cycle_seq_pkg::TRANS_I, 1'b0, 1'b0);
      end
      row(fp, cycle_seq_pkg::TRANS_S, 1'b0, 1'b0);
      fp = fp + 4;
    end
    $display("test multiply done");
    multi(cycle_seq_pkg::kind_multi_load, 5'h3);
    multi(cycle_seq_pkg::kind_multi_store, 5'($urandom_range(4, 1)));
    issue(cycle_seq_pkg::kind_data, 1'b1, 32'h0);
    row(fp, cycle_seq_pkg::TRANS_S, 1'b0, 1'b1);
    issue(cycle_seq_pkg::kind_coproc_data_op, 1'b1, 32'h0);
    row(fp + 4, cycle_seq_pkg::TRANS_S, 1'b0, 1'b1);
    issue(cycle_seq_pkg::kind_move_to_coproc, 1'b1, 32'h0);
    row(fp + 8, cycle_seq_pkg::TRANS_C, 1'b0, 1'b1);
    row(fp, cycle_seq_pkg::TRANS_N, 1'b0, 1'b0);
    chk("cp_write", 32'h1, bus_write);
    issue(cycle_seq_pkg::kind_move_from_coproc, 1'b1, 32'h0);
    row(fp + 12, cycle_seq_pkg::TRANS_C, 1'b0, 1'b1);
    row(fp, cycle_seq_pkg::TRANS_I, 1'b0, 1'b0);
    row(fp, cycle_seq_pkg::TRANS_S, 1'b0, 1'b0);
    fp = fp + 16;
    $display("test coproc done");
    stall_on <= 1'b1;
    branch(cycle_seq_pkg::kind_branch_exchange, 32'h3001);
    issue(cycle_seq_pkg::kind_long_link_hi, 1'b1, 32'h40);
    row(fp, cycle_seq_pkg::TRANS_S, 1'b1, 1'b1);
    chk("link_hi", fp + 32'h40, link_register);
    fp = fp + 2;
    branch(cycle_seq_pkg::kind_long_link_lo, $urandom & 32'hfffffffe);
    branch(cycle_seq_pkg::kind_branch_exchange, 32'h4000);
    stall_on <= 1'b0;
    apb(1'b0, cycle_seq_pkg::LINK_OFFSET, 32'h0);
    chk("link_read", lk, q);
    apb(1'b0, cycle_seq_pkg::STATUS_OFFSET, 32'h0);
    chk("status", {30'h0, nar, 1'b0}, q);
    $display("test readback done");
    summarize();
  end
endmodule
